// ==== rtl/ipg_core.sv ====
// Idle, idle immediate and geometry command interpreter with an AHB-Lite register slave.
//
// Function
// - Idle opcode enters idle at once and loads then starts the standby countdown.
// - Entering idle requests spin-up unless the spindle already rotates.
// - Timeout code zero disables the countdown, any other value enables it.
// - Codes 1 to 240 give the code times five seconds.
// - Codes 241 to 251 give the code minus 240 times thirty minutes.
// - Code 252 is 21 min, 253 is 8 h, 255 is 21 min 15 s; 254 aborts.
// - Enabled countdown expiring with no host access moves the drive to standby.
// - Any host access before expiry reloads the full configured interval.
// - Idle keeps spindle rotating and services new commands without spin-up delay.
// - Idle immediate opcode enters idle with the same spin-up behaviour.
// - Idle immediate leaves the stored countdown setting unchanged.
// - Geometry opcode stores sectors per track and heads minus one from low nibble.
// - Geometry holds until new command, power-off, or soft reset in reverting mode.
// - Sectors per track zero means zero, never 256.
// - Heads minus one field is limited to 0 through 15.
// - Stored geometry is reported in the identify current geometry words.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module ipg_core
    import ipg_pkg::*;
#(
    parameter int TICKS_PER_SEC = IPG_CLK_HZ
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Spindle interface.
    input  wire logic        spindle_at_speed,
    output logic             spin_up_req,
    output logic             standby_req,
    // Identify words of the current logical geometry.
    output logic      [15:0] id_cur_heads,
    output logic      [15:0] id_cur_sectors,
    // Interrupt.
    output logic             irq
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Converts a standby timeout code into seconds; zero means disabled.
    function automatic logic [31:0] timeout_secs(input logic [7:0] code);
        logic [31:0] c;
        c = {24'h00_0000, code};
        if (code <= IPG_TO_SHORT_MAX) begin
            timeout_secs = c * IPG_SHORT_STEP_S;
        end else if (code <= IPG_TO_LONG_MAX) begin
            timeout_secs = (c - {24'h00_0000, IPG_TO_SHORT_MAX}) * IPG_LONG_STEP_S;
        end else if (code == IPG_TO_C252) begin
            timeout_secs = IPG_C252_S;
        end else if (code == IPG_TO_C253) begin
            timeout_secs = IPG_C253_S;
        end else begin
            timeout_secs = IPG_C255_S;
        end
    endfunction : timeout_secs

    // Word offset match on the captured address.
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
        addr_is = (a == ofs);
    endfunction : addr_is

    // ------------------------------------------------------------------
    // AHB-Lite address phase capture
    // ------------------------------------------------------------------
    logic        wr_pend_q;
    logic [7:0]  addr_q;
    logic        take;
    logic        wr_en;

    // Takes a transfer whenever a NONSEQ or SEQ arrives with the bus ready.
    // The slave never stalls, so each phase lasts one cycle.
    assign take      = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_en     = wr_pend_q;

    // Captures the address of each accepted transfer for the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            wr_pend_q <= take && hwrite;
            if (take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Decoded writes
    // ------------------------------------------------------------------
    ipg_taskfile_t tf;
    logic          cmd_wr;
    logic          host_access;
    logic          soft_reset;
    logic          is_idle;
    logic          is_idli;
    logic          is_geom;
    logic          bad_code;
    logic          reject;

    // Splits the command word and decodes the opcode.
    assign tf          = ipg_taskfile_t'(hwdata[23:0]);
    assign cmd_wr      = wr_en && addr_is(addr_q, IPG_OFS_CMD);
    assign soft_reset  = wr_en && addr_is(addr_q, IPG_OFS_CTRL) && hwdata[IPG_CTL_SRST];
    assign is_idle     = (tf.command == IPG_OP_IDLE) || (tf.command == IPG_OP_IDLE_OLD);
    assign is_idli     = (tf.command == IPG_OP_IDLI) || (tf.command == IPG_OP_IDLI_OLD);
    assign is_geom     = (tf.command == IPG_OP_GEOM);
    assign bad_code    = is_idle && (tf.sec_count == IPG_TO_C254);
    assign reject      = cmd_wr && (bad_code || !(is_idle || is_idli || is_geom));
    // Every command or explicit access write counts as host drive access.
    assign host_access = cmd_wr || (wr_en && addr_is(addr_q, IPG_OFS_ACCESS));

    // ------------------------------------------------------------------
    // Soft reset mode: reverting (set) or preserving (clear) geometry
    // ------------------------------------------------------------------
    logic revert_q;

    // Holds the soft reset option chosen by software.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            revert_q <= 1'b0;
        end else if (wr_en && addr_is(addr_q, IPG_OFS_CTRL)) begin
            revert_q <= hwdata[IPG_CTL_REVT];
        end
    end

    // ------------------------------------------------------------------
    // Geometry store
    // ------------------------------------------------------------------
    ipg_geom_t geom_q;

    // Stores the geometry, kept across soft reset unless reverting is chosen.
    // A geometry command beats a reverting soft reset in one cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            geom_q <= '0;
        end else if (cmd_wr && is_geom) begin
            geom_q.sectors  <= tf.sec_count;
            geom_q.heads_m1 <= tf.dev_head[3:0];
        end else if (soft_reset && revert_q) begin
            geom_q <= '0;
        end
    end

    // Presents the stored geometry to the identify data assembler.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            id_cur_heads   <= 16'h0000;
            id_cur_sectors <= 16'h0000;
        end else begin
            id_cur_heads   <= {11'h000, 5'(geom_q.heads_m1) + 5'h01};
            id_cur_sectors <= {8'h00, geom_q.sectors};
        end
    end

    // ------------------------------------------------------------------
    // Command result: status and error
    // ------------------------------------------------------------------
    ipg_result_t res_q;

    // Completes each command at once; busy is never left set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_q <= '0;
        end else if (cmd_wr) begin
            res_q.status                <= '0;
            res_q.status[IPG_ST_RDY]    <= 1'b1;
            res_q.status[IPG_ST_DSC]    <= 1'b1;
            res_q.status[IPG_ST_BSY]    <= 1'b0;
            res_q.status[IPG_ST_ERR]    <= reject;
            res_q.error                 <= '0;
            res_q.error[IPG_ERR_ABT]    <= reject;
        end
    end

    // ------------------------------------------------------------------
    // Standby timer setting and countdown
    // ------------------------------------------------------------------
    logic [7:0]  to_code_q;
    logic [31:0] sec_left_q;
    logic [31:0] tick_q;
    logic        sec_tick;
    logic        timer_en;
    logic        expire;
    ipg_pwr_t    pwr_q;

    // Timer enable, one-second strobe and expiry.
    // An access in the expiry cycle wins and reloads instead.
    assign timer_en = (to_code_q != 8'h00);
    assign sec_tick = (tick_q == 32'(TICKS_PER_SEC - 1));
    assign expire   = timer_en && (pwr_q != IPG_PWR_STANDBY) && sec_tick
                      && (sec_left_q == 32'h0000_0001) && !host_access;

    // Keeps the timeout code; only the idle command changes it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            to_code_q <= 8'h00;
        end else if (cmd_wr && is_idle && !bad_code) begin
            to_code_q <= tf.sec_count;
        end
    end

    // Divides the clock into one-second enable pulses, restarted by any access.
    // The restart gives a reloaded count a full first second.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 32'h0000_0000;
        end else if (host_access || sec_tick) begin
            tick_q <= 32'h0000_0000;
        end else begin
            tick_q <= tick_q + 32'h0000_0001;
        end
    end

    // Counts the seconds left, reloaded on new setting or any host access.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_left_q <= 32'h0000_0000;
        end else if (cmd_wr && is_idle && !bad_code) begin
            sec_left_q <= (tf.sec_count == 8'h00) ? 32'h0000_0000
                                                  : timeout_secs(tf.sec_count);
        end else if (host_access) begin
            sec_left_q <= timer_en ? timeout_secs(to_code_q) : 32'h0000_0000;
        end else if (timer_en && sec_tick && sec_left_q != 32'h0000_0000) begin
            sec_left_q <= sec_left_q - 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Power mode and spindle requests
    // ------------------------------------------------------------------
    logic enter_idle;

    // A reserved timeout code never enters idle.
    assign enter_idle = cmd_wr && ((is_idle && !bad_code) || is_idli);

    // Tracks the power mode and falls to standby when the countdown expires.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_q <= IPG_PWR_ACTIVE;
        end else begin
            case (pwr_q)
                IPG_PWR_ACTIVE, IPG_PWR_IDLE: begin
                    if (enter_idle) begin
                        pwr_q <= IPG_PWR_IDLE;
                    end else if (expire) begin
                        pwr_q <= IPG_PWR_STANDBY;
                    end
                end
                IPG_PWR_STANDBY: begin
                    if (enter_idle) begin
                        pwr_q <= IPG_PWR_IDLE;
                    end
                end
                default: pwr_q <= IPG_PWR_ACTIVE;
            endcase
        end
    end

    // Asks for spin-up while idle and not at speed; no request when already spinning.
    // Expiry masks the request so a stopping drive is not spun up.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spin_up_req <= 1'b0;
            standby_req <= 1'b0;
        end else begin
            spin_up_req <= ((pwr_q == IPG_PWR_IDLE) || enter_idle)
                           && !spindle_at_speed && !expire;
            standby_req <= (pwr_q == IPG_PWR_STANDBY) && !enter_idle;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, enable and clear
    // ------------------------------------------------------------------
    logic [IPG_IRQ_W-1:0] ist_q;
    logic [IPG_IRQ_W-1:0] ien_q;
    logic [IPG_IRQ_W-1:0] ev;
    logic [IPG_IRQ_W-1:0] clr;
    logic                 spin_q;

    // Events are speed reached, expiry, abort and command done.
    assign ev  = {spindle_at_speed && !spin_q, expire, reject, cmd_wr};
    assign clr = (wr_en && addr_is(addr_q, IPG_OFS_IRQ_CL)) ? hwdata[IPG_IRQ_W-1:0] : '0;

    // Sets sticky status on events; a set in the clear cycle wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ist_q  <= '0;
            ien_q  <= '0;
            spin_q <= 1'b0;
            irq    <= 1'b0;
        end else begin
            spin_q <= spindle_at_speed;
            ist_q  <= (ist_q & ~clr) | ev;
            if (wr_en && addr_is(addr_q, IPG_OFS_IRQ_EN)) begin
                ien_q <= hwdata[IPG_IRQ_W-1:0];
            end
            // The line follows the next status, so it rises with the flag.
            irq <= |(((ist_q & ~clr) | ev) & ien_q);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------

    // Drives read data for the captured address; unmapped reads give zero.
    // Reads have no side effects, so polling never clears a flag.
    always_comb begin
        hrdata = 32'h0000_0000;
        case (addr_q)
            IPG_OFS_RESULT: hrdata = {16'h0000, res_q};
            IPG_OFS_GEOM:   hrdata = {20'h0_0000, geom_q};
            IPG_OFS_TIMER:  hrdata = {sec_left_q[23:0], to_code_q};
            IPG_OFS_POWER:  hrdata = {29'h0000_0000, spin_up_req, 2'(pwr_q)};
            IPG_OFS_IRQ_ST: hrdata = {28'h000_0000, ist_q};
            IPG_OFS_IRQ_EN: hrdata = {28'h000_0000, ien_q};
            IPG_OFS_CTRL:   hrdata = {30'h0000_0000, revert_q, 1'b0};
            default:        hrdata = 32'h0000_0000;
        endcase
    end

endmodule : ipg_core

// ==== rtl/ipg_pkg.sv ====
// Package of constants, types and register map for the idle power and geometry command block.
package ipg_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the AHB-Lite bus)
    // ------------------------------------------------------------------
    localparam logic [7:0] IPG_OFS_CMD    = 8'h00;
    localparam logic [7:0] IPG_OFS_RESULT = 8'h04;
    localparam logic [7:0] IPG_OFS_GEOM   = 8'h08;
    localparam logic [7:0] IPG_OFS_TIMER  = 8'h0C;
    localparam logic [7:0] IPG_OFS_POWER  = 8'h10;
    localparam logic [7:0] IPG_OFS_IRQ_ST = 8'h14;
    localparam logic [7:0] IPG_OFS_IRQ_CL = 8'h18;
    localparam logic [7:0] IPG_OFS_IRQ_EN = 8'h1C;
    localparam logic [7:0] IPG_OFS_CTRL   = 8'h20;
    localparam logic [7:0] IPG_OFS_ACCESS = 8'h24;

    // ------------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] IPG_OP_IDLE     = 8'hE3;
    localparam logic [7:0] IPG_OP_IDLE_OLD = 8'h97;
    localparam logic [7:0] IPG_OP_IDLI     = 8'hE1;
    localparam logic [7:0] IPG_OP_IDLI_OLD = 8'h95;
    localparam logic [7:0] IPG_OP_GEOM     = 8'h91;

    // ------------------------------------------------------------------
    // Timeout code decode points and intervals in seconds
    // ------------------------------------------------------------------
    localparam logic [7:0]  IPG_TO_SHORT_MAX = 8'hF0;
    localparam logic [7:0]  IPG_TO_LONG_MAX  = 8'hFB;
    localparam logic [7:0]  IPG_TO_C252      = 8'hFC;
    localparam logic [7:0]  IPG_TO_C253      = 8'hFD;
    localparam logic [7:0]  IPG_TO_C254      = 8'hFE;
    localparam logic [31:0] IPG_SHORT_STEP_S = 32'h0000_0005;
    localparam logic [31:0] IPG_LONG_STEP_S  = 32'h0000_0708;
    localparam logic [31:0] IPG_C252_S       = 32'h0000_04EC;
    localparam logic [31:0] IPG_C253_S       = 32'h0000_7080;
    localparam logic [31:0] IPG_C255_S       = 32'h0000_04FB;

    // ------------------------------------------------------------------
    // Clock figures
    // ------------------------------------------------------------------
    localparam int IPG_CLK_HZ = 250_000_000;

    // ------------------------------------------------------------------
    // Error and status bit positions, interrupt bits, control bits
    // ------------------------------------------------------------------
    localparam int IPG_ERR_ABT   = 2;
    localparam int IPG_ST_ERR    = 0;
    localparam int IPG_ST_DSC    = 4;
    localparam int IPG_ST_RDY    = 6;
    localparam int IPG_ST_BSY    = 7;
    localparam int IPG_IRQ_DONE  = 0;
    localparam int IPG_IRQ_ABORT = 1;
    localparam int IPG_IRQ_STBY  = 2;
    localparam int IPG_IRQ_SPIN  = 3;
    localparam int IPG_IRQ_W     = 4;
    localparam int IPG_CTL_SRST  = 0;
    localparam int IPG_CTL_REVT  = 1;
    localparam int IPG_CTL_SPUP  = 2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {IPG_PWR_ACTIVE, IPG_PWR_IDLE, IPG_PWR_STANDBY} ipg_pwr_t;

    typedef struct packed {
        logic [7:0] command;
        logic [7:0] dev_head;
        logic [7:0] sec_count;
    } ipg_taskfile_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] error;
    } ipg_result_t;

    typedef struct packed {
        logic [3:0] heads_m1;
        logic [7:0] sectors;
    } ipg_geom_t;

endpackage : ipg_pkg

// ==== tb/ipg_core_assertions.sv ====
// Concurrent checks on the ports of the idle power and geometry command block.
`timescale 1ns/1ps
module ipg_core_assertions
    import ipg_pkg::*;
#(
    parameter int TICKS_PER_SEC = 10
) (
    // Clock and reset.
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus signals.
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Spindle, identify words and interrupt.
    input wire logic        spindle_at_speed,
    input wire logic        spin_up_req,
    input wire logic        standby_req,
    input wire logic [15:0] id_cur_heads,
    input wire logic [15:0] id_cur_sectors,
    input wire logic        irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Address phase of a write to one offset, then a command data phase.
    sequence s_wr(logic [7:0] ofs);
        hsel && hready && htrans[1] && hwrite && haddr[7:0] == ofs;
    endsequence
    sequence s_cmd(logic [7:0] op);
        s_wr(IPG_OFS_CMD) ##1 hwdata[23:16] == op;
    endsequence
    // A geometry command shows in the identify words two edges after its data phase.
    property p_geom;
        logic [7:0] s;
        logic [3:0] h;
        (s_wr(IPG_OFS_CMD) ##1 (hwdata[23:16] == IPG_OP_GEOM, s = hwdata[7:0], h = hwdata[11:8]))
        |-> ##2 (id_cur_sectors == {8'h00, s} && id_cur_heads == 16'(h) + 16'h0001);
    endproperty

    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_heads_in_range: assert property ($past(hresetn) |-> id_cur_heads inside {[1:16]})
        else $error("head count outside one to sixteen");
    a_sectors_below_256: assert property (id_cur_sectors[15:8] == 8'h00)
        else $error("sector count above 255");
    a_spin_skip_rotating: assert property ($past(spindle_at_speed) |-> !spin_up_req)
        else $error("spin-up requested while rotating");
    a_irq_masked_off: assert property (s_wr(IPG_OFS_IRQ_EN) ##1 hwdata[3:0] == 4'h0 |-> ##3 !irq)
        else $error("interrupt high with all enables clear");
    a_access_reloads: assert property (s_wr(IPG_OFS_ACCESS) ##0 !standby_req
        |-> ##3 !standby_req [*8])
        else $error("standby soon after a host access");
    a_idle_wakes_up: assert property (s_cmd(IPG_OP_IDLI) or s_cmd(IPG_OP_IDLI_OLD)
        |-> ##[1:3] !standby_req)
        else $error("idle immediate left standby active");
    a_geom_reported: assert property (p_geom)
        else $error("identify words differ from geometry command");
endmodule : ipg_core_assertions

bind ipg_core ipg_core_assertions #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .spindle_at_speed(spindle_at_speed),
    .spin_up_req(spin_up_req), .standby_req(standby_req), .id_cur_heads(id_cur_heads),
    .id_cur_sectors(id_cur_sectors), .irq(irq));

// ==== tb/ipg_core_test.sv ====
// Self-checking bench for the idle power and geometry command block.
`timescale 1ns/1ps
module ipg_core_test;
    import ipg_pkg::*;
    localparam int T = 10;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, at_speed, spin_up_req, standby_req, irq;
    logic [15:0] id_h, id_s;
    logic [7:0]  codes [9], s;
    logic [3:0]  h;
    int          n_mismatch = 0, checks_done = 0, n;

    always #2 hclk = ~hclk;

    ipg_core #(.TICKS_PER_SEC(T)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .spindle_at_speed(at_speed), .spin_up_req(spin_up_req), .standby_req(standby_req),
        .id_cur_heads(id_h), .id_cur_sectors(id_s), .irq(irq));
    ipg_spindle_model u_spin (.hclk(hclk), .hresetn(hresetn), .spin_up_req(spin_up_req),
        .standby_req(standby_req), .slow(slow), .spindle_at_speed(at_speed));

    task automatic report_and_stop;
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk

    // Waits for the edge at which the slave is ready, under a bound.
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && k < 50) begin
            k++;
            @(posedge hclk);
        end
        if (k >= 50) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : wait_rdy

    // One single word transfer; read data land in rd.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : xfer

    task automatic cmd(input logic [7:0] op, input logic [7:0] dh, input logic [7:0] sc);
        xfer(1'b1, IPG_OFS_CMD, {8'h00, op, dh, sc});
    endtask : cmd

    task automatic rdck(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rdck

    function automatic logic [23:0] exp_secs(input logic [7:0] c);
        case (c)
            8'hFC: return 24'h00_04EC;
            8'hFD: return 24'h00_7080;
            8'hFF: return 24'h00_04FB;
            default: return (c <= 8'hF0) ? 24'(c) * 24'h00_0005 : 24'(c - 8'hF0) * 24'h00_0708;
        endcase
    endfunction : exp_secs

    initial begin
        rd = $urandom(93);
        codes = '{8'h01, 8'hF0, 8'hF1, 8'hFB, 8'hFC, 8'hFD, 8'hFF, 8'h00, 8'h00};
        codes[8] = 8'($urandom_range(251, 1));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b1, IPG_OFS_IRQ_EN, 32'h0000_000F);
        rdck("unmapped", 8'h3C, 32'h0000_0000);
        // Every class of timeout code through both idle opcodes.
        foreach (codes[i]) begin
            cmd(i % 2 ? IPG_OP_IDLE_OLD : IPG_OP_IDLE, 8'hA0, codes[i]);
            rdck("power", IPG_OFS_POWER, i == 0 ? 32'h0000_0005 : 32'h0000_0001);
            xfer(1'b0, IPG_OFS_TIMER, 32'h0000_0000);
            chk("code", codes[i], rd[7:0]);
            if (codes[i] != 8'h00) chk("secs", 1, rd[31:8] == exp_secs(codes[i]) || rd[31:8] + 1 == exp_secs(codes[i]));
            chk("irq", 1, irq);
        end
        // Reserved code and an unknown opcode are refused.
        cmd(IPG_OP_IDLE, 8'hA0, 8'hFE);
        xfer(1'b0, IPG_OFS_RESULT, 32'h0000_0000);
        chk("error", 32'h0000_0004, {rd[31:16], 8'h00, rd[7:0]});
        chk("status", 2'b01, {rd[15], rd[8]});
        rdck("kept", IPG_OFS_TIMER, {exp_secs(codes[8]), codes[8]});
        cmd(8'h00, 8'hA0, 8'h05);
        xfer(1'b0, IPG_OFS_RESULT, 32'h0000_0000);
        chk("unknown", 8'h04, rd[7:0]);
        // Standby after the shortest interval, with one reload.
        cmd(IPG_OP_IDLE, 8'hA0, 8'h01);
        repeat (20) @(posedge hclk);
        xfer(1'b1, IPG_OFS_ACCESS, 32'h0000_0000);
        n = 0;
        while (!standby_req && n < 6 * T) begin
            n++;
            @(posedge hclk);
        end
        chk("standby wait", 1, n >= 4 * T - 2 && n <= 5 * T + 4);
        rdck("power sb", IPG_OFS_POWER, 32'h0000_0002);
        xfer(1'b0, IPG_OFS_IRQ_ST, 32'h0000_0000);
        chk("sb flag", 1, rd[IPG_IRQ_STBY]);
        xfer(1'b1, IPG_OFS_IRQ_CL, 32'h0000_000F);
        rdck("cleared", IPG_OFS_IRQ_ST, 32'h0000_0000);
        xfer(1'b1, IPG_OFS_IRQ_EN, 32'h0000_0000);
        // Idle immediate from standby with a slow spindle keeps the code.
        slow <= 1'b1;
        cmd(IPG_OP_IDLI, 8'hA0, 8'h00);
        repeat (3) @(posedge hclk);
        chk("spin req", 1, spin_up_req);
        xfer(1'b0, IPG_OFS_TIMER, 32'h0000_0000);
        chk("code kept", 8'h01, rd[7:0]);
        chk("no irq", 0, irq);
        n = 0;
        while (!at_speed && n < 60) begin
            n++;
            @(posedge hclk);
        end
        chk("spin wait", 1, n < 60);
        repeat (2) @(posedge hclk);
        chk("spin done", 0, spin_up_req);
        cmd(IPG_OP_IDLI_OLD, 8'hA0, 8'h00);
        rdck("power ii", IPG_OFS_POWER, 32'h0000_0001);
        // Geometry, zero sectors first, heads over the whole field.
        for (int i = 0; i < 6; i++) begin
            s = i == 0 ? 8'h00 : 8'($urandom_range(255, 0));
            h = i == 1 ? 4'hF : 4'($urandom_range(15, 0));
            cmd(IPG_OP_GEOM, {4'hA, h}, s);
            rdck("geom", IPG_OFS_GEOM, {20'h0_0000, h, s});
            chk("id", {16'(h) + 16'h0001, 8'h00, s}, {id_h, id_s});
        end
        xfer(1'b1, IPG_OFS_CTRL, 32'h0000_0001);
        rdck("geom kept", IPG_OFS_GEOM, {20'h0_0000, h, s});
        xfer(1'b1, IPG_OFS_CTRL, 32'h0000_0002);
        xfer(1'b1, IPG_OFS_CTRL, 32'h0000_0003);
        xfer(1'b0, IPG_OFS_CTRL, 32'h0000_0000);
        chk("revert", 1, rd[IPG_CTL_REVT]);
        rdck("geom gone", IPG_OFS_GEOM, 32'h0000_0000);
        chk("id gone", 32'h0001_0000, {id_h, id_s});
        report_and_stop();
    end
endmodule : ipg_core_test

// ==== tb/ipg_spindle_model.sv ====
// Behavioural spindle that reaches speed a while after a spin-up request.
`timescale 1ns/1ps
module ipg_spindle_model (
    // Clock and reset.
    input  wire logic hclk,
    input  wire logic hresetn,
    // Requests from the block and speed choice of the bench.
    input  wire logic spin_up_req,
    input  wire logic standby_req,
    input  wire logic slow,
    // Speed indication.
    output logic      spindle_at_speed
);
    int cnt;
    // Spins up after a short or long delay and spins down in standby.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            spindle_at_speed <= 1'b0;
        end else if (standby_req) begin
            cnt <= 0;
            spindle_at_speed <= 1'b0;
        end else if (spin_up_req && !spindle_at_speed) begin
            cnt <= cnt + 1;
            spindle_at_speed <= (cnt >= (slow ? 40 : 3));
        end
    end
endmodule : ipg_spindle_model
